// File: rtl/status_params.svh
/*
  constants of the status register bank: bus offsets, field masks, timing.
  assumes a 25 mhz pclk and a 32-bit apb with byte addresses.
*/
// How it works
// - an event bit is zero until its monitored event happens, then it latches to one.
// - a latched event bit stays set after its cause goes away until read, clear-status or reset command.
// - reading a group event register returns it and then clears its bits except any rising that cycle; reading the questionable event register clears nothing.
// - reading a condition register has no side effect.
// - condition bits follow the present monitored state with no latching.
// - the enable mask never changes which event or condition bits are set.
// - a group summary bit is driven only by group bits whose enable bit is one.
// - +5 v current above its limit sets bit 2 of the current event and condition.
// - clear-status zeroes all events and any condition still present sets it again.
// - while a current is over its limit a flashing alarm is driven, removed when clear.
// - an event bit is set on a false-to-true change of its condition bit, or after a clear-status or reset command while it is still true.
// - unused event and condition bit positions always read zero.
// - the preset command loads every group enable mask with zero; the interrupt enable keeps its value.
`ifndef STATUS_PARAMS_SVH
`define STATUS_PARAMS_SVH

`define NUM_GROUPS      6
`define GRP_W           16
// group order: current, voltage, power, temperature, fan, bus monitor
`define GRP_USED_MASK   {16'h00ff, 16'h00ff, 16'h00ff, 16'h00ff, 16'h00ff, 16'h00ff}
`define CUR_GROUP       0
`define P5_CUR_BIT      2

`define OFS_GRP_STRIDE  8'h10
`define OFS_EVT         4'h0
`define OFS_COND        4'h4
`define OFS_EN          4'h8
`define OFS_QUES_EVT    8'h60
`define OFS_QUES_COND   8'h64
`define OFS_CMD         8'h68
`define OFS_P5_LIMIT    8'h6c
`define OFS_IRQ_STS     8'h70
`define OFS_IRQ_EN      8'h74
`define OFS_IRQ_CLR     8'h78

`define CMD_CLS_BIT     0
`define CMD_PRESET_BIT  1
`define CMD_RST_BIT     2

`define LIMIT_RESET     16'hffff
`define EN_PRESET       16'h0000

`define CLK_KHZ         25000
`define BLINK_HALF_MS   250

`endif

// File: rtl/status_pkg.sv
/*
  types shared by the status register bank.
  assumes status_params.svh is on the include path.
*/
`include "status_params.svh"
package status_pkg;
  typedef logic [`GRP_W-1:0] grp_word_t;
  typedef struct packed {
    logic            wr;    // write access completes
    logic            rd;    // read access completes
    logic [7:0]      addr;  // byte address
    logic [31:0]     wdata; // write data
  } bus_op_t;
endpackage

// File: rtl/status_bank.sv
/*
  status condition / event / enable bank for six monitored groups, with an
  apb slave, questionable summary bits, interrupt and a flashing alarm.
  assumes monitor condition pins are asynchronous, p5 current is a measured
  value from logic on pclk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "status_params.svh"
module status_bank
  import status_pkg::*;
#(
  parameter int BLINK_CYCLES = `BLINK_HALF_MS * `CLK_KHZ
) (
  input  wire logic        pclk,          // 25 mhz clock
  input  wire logic        presetn,       // async reset, active low
  input  wire logic        psel,          // apb select
  input  wire logic        penable,       // apb enable
  input  wire logic        pwrite,        // apb direction
  input  wire logic [7:0]  paddr,         // apb byte address
  input  wire logic [31:0] pwdata,        // apb write data
  output logic      [31:0] prdata,        // apb read data
  output logic             pready,        // apb ready
  output logic             pslverr,       // apb error on unmapped address
  input  wire logic [95:0] monitor_cond,  // raw monitor conditions, 16/group
  input  wire logic [15:0] p5_current,    // measured +5 v current, pclk domain
  output logic             irq,           // level interrupt
  output logic             alarm_flash    // flashing front-panel alarm
);
  localparam int NG = `NUM_GROUPS;
  localparam logic [NG*`GRP_W-1:0] USED = `GRP_USED_MASK;

  // ==========================================================================
  // apb slave: one wait cycle, result registered
  // ==========================================================================
  logic        pready_q, pready_d;
  logic        pslverr_q, pslverr_d;
  logic [31:0] prdata_q, prdata_d;
  logic        acc, rd_take;
  bus_op_t     op;
  logic [31:0] rd_val;
  logic        rd_hit;

  assign acc     = psel & penable & ~pready_q;
  // an event read clears on the edge that captures prdata, so a bit that
  // rises while pready is pending is kept for the next read, not lost
  assign rd_take = acc & ~pwrite;
  assign op      = '{wr:    psel & penable & pready_q & pwrite,
                     rd:    psel & penable & pready_q & ~pwrite,
                     addr:  paddr,
                     wdata: pwdata};

  // ==========================================================================
  // condition synchroniser and +5 v comparator
  // ==========================================================================
  logic [95:0] sync1_q, sync2_q;
  logic        over_q, over_d;
  logic [15:0] limit_q, limit_d;
  logic        cmd_wr, cls, preset, rst_cmd;

  assign cmd_wr  = op.wr & (op.addr == `OFS_CMD);
  assign cls     = cmd_wr & op.wdata[`CMD_CLS_BIT];
  assign preset  = cmd_wr & op.wdata[`CMD_PRESET_BIT];
  assign rst_cmd = cmd_wr & op.wdata[`CMD_RST_BIT];

  always_comb begin
    over_d  = p5_current > limit_q;
    limit_d = limit_q;
    if (op.wr && op.addr == `OFS_P5_LIMIT) begin
      limit_d = op.wdata[15:0];
    end
  end

  // ==========================================================================
  // per-group condition, event and enable
  // ==========================================================================
  grp_word_t      cond_now [NG];
  grp_word_t      evt_q    [NG];
  grp_word_t      en_q     [NG];
  grp_word_t      prev_q   [NG];
  logic [NG-1:0]  sum_evt, sum_cond, grp_event;

  for (genvar g = 0; g < NG; g++) begin : g_grp
    grp_word_t evt_d, en_d, prev_d, rise, mask;
    logic      sel, clr;
    assign mask = USED[g*`GRP_W +: `GRP_W];
    assign sel  = (op.addr[7:4] == 4'(g)) && (op.addr < `OFS_QUES_EVT);

    always_comb begin
      cond_now[g] = sync2_q[g*`GRP_W +: `GRP_W] & mask;
      if (g == `CUR_GROUP) begin
        cond_now[g][`P5_CUR_BIT] = over_q;
      end
    end

    always_comb begin
      rise   = cond_now[g] & ~prev_q[g];
      clr    = (rd_take && sel && op.addr[3:0] == `OFS_EVT)
               || cls || rst_cmd;
      // a new edge in the clearing cycle survives the clear
      evt_d  = (clr ? '0 : evt_q[g]) | rise;
      // forgetting the old level makes a lasting condition re-trigger
      prev_d = (cls || rst_cmd) ? '0 : cond_now[g];
      en_d   = en_q[g];
      if (preset) begin
        en_d = `EN_PRESET;
      end else if (op.wr && sel && op.addr[3:0] == `OFS_EN) begin
        en_d = op.wdata[`GRP_W-1:0];
      end
    end

    assign sum_evt[g]   = |(evt_q[g] & en_q[g]);
    assign sum_cond[g]  = |(cond_now[g] & en_q[g]);
    assign grp_event[g] = |rise;

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        evt_q[g]  <= '0;
        en_q[g]   <= `EN_PRESET;
        prev_q[g] <= '0;
      end else begin
        evt_q[g]  <= evt_d;
        en_q[g]   <= en_d;
        prev_q[g] <= prev_d;
      end
    end
  end

  // ==========================================================================
  // interrupt status, enable, clear
  // ==========================================================================
  logic [NG-1:0] irq_sts_q, irq_sts_d, irq_en_q, irq_en_d;
  logic          irq_q, irq_d;

  always_comb begin
    irq_sts_d = irq_sts_q;
    if (op.wr && op.addr == `OFS_IRQ_CLR) begin
      irq_sts_d = irq_sts_q & ~op.wdata[NG-1:0];
    end
    irq_sts_d = irq_sts_d | grp_event;
    irq_en_d  = irq_en_q;
    if (op.wr && op.addr == `OFS_IRQ_EN) begin
      irq_en_d = op.wdata[NG-1:0];
    end
    irq_d = |(irq_sts_q & irq_en_q);
  end

  // ==========================================================================
  // flashing alarm: blink counter runs only while a current is over limit
  // ==========================================================================
  logic [31:0] blink_cnt_q, blink_cnt_d;
  logic        blink_q, blink_d, alarm_q, alarm_d, cur_over;

  assign cur_over = |cond_now[`CUR_GROUP];

  always_comb begin
    blink_cnt_d = blink_cnt_q;
    blink_d     = blink_q;
    if (!cur_over) begin
      blink_cnt_d = '0;
      blink_d     = 1'b1;
    end else if (blink_cnt_q == 32'(BLINK_CYCLES - 1)) begin
      blink_cnt_d = '0;
      blink_d     = ~blink_q;
    end else begin
      blink_cnt_d = blink_cnt_q + 32'h1;
    end
    alarm_d = cur_over & blink_q;
  end

  // ==========================================================================
  // read mux
  // ==========================================================================
  always_comb begin
    rd_val = '0;
    rd_hit = 1'b1;
    if (paddr < `OFS_QUES_EVT && paddr[7:4] < 4'(NG)) begin
      case (paddr[3:0])
        `OFS_EVT:  rd_val = 32'(evt_q[paddr[6:4]]);
        `OFS_COND: rd_val = 32'(cond_now[paddr[6:4]]);
        `OFS_EN:   rd_val = 32'(en_q[paddr[6:4]]);
        default:   rd_hit = 1'b0;
      endcase
    end else begin
      case (paddr)
        `OFS_QUES_EVT:  rd_val = 32'(sum_evt);
        `OFS_QUES_COND: rd_val = 32'(sum_cond);
        `OFS_CMD:       rd_val = '0;
        `OFS_P5_LIMIT:  rd_val = 32'(limit_q);
        `OFS_IRQ_STS:   rd_val = 32'(irq_sts_q);
        `OFS_IRQ_EN:    rd_val = 32'(irq_en_q);
        `OFS_IRQ_CLR:   rd_val = '0;
        default:        rd_hit = 1'b0;
      endcase
    end
    pready_d  = acc;
    pslverr_d = acc & ~rd_hit;
    prdata_d  = acc ? (pwrite ? '0 : rd_val) : prdata_q;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q     <= '0;
      sync2_q     <= '0;
      over_q      <= 1'b0;
      limit_q     <= `LIMIT_RESET;
      irq_sts_q   <= '0;
      irq_en_q    <= '0;
      irq_q       <= 1'b0;
      blink_cnt_q <= '0;
      blink_q     <= 1'b1;
      alarm_q     <= 1'b0;
      pready_q    <= 1'b0;
      pslverr_q   <= 1'b0;
      prdata_q    <= '0;
    end else begin
      sync1_q     <= monitor_cond;
      sync2_q     <= sync1_q;
      over_q      <= over_d;
      limit_q     <= limit_d;
      irq_sts_q   <= irq_sts_d;
      irq_en_q    <= irq_en_d;
      irq_q       <= irq_d;
      blink_cnt_q <= blink_cnt_d;
      blink_q     <= blink_d;
      alarm_q     <= alarm_d;
      pready_q    <= pready_d;
      pslverr_q   <= pslverr_d;
      prdata_q    <= prdata_d;
    end
  end

  assign prdata      = prdata_q;
  assign pready      = pready_q;
  assign pslverr     = pslverr_q;
  assign irq         = irq_q;
  assign alarm_flash = alarm_q;

  // ==========================================================================
  // assertions
  // ==========================================================================
  property p_evt_latch;
    @(posedge pclk) disable iff (!presetn)
    (cond_now[0][`P5_CUR_BIT] && !prev_q[0][`P5_CUR_BIT])
      |=> evt_q[0][`P5_CUR_BIT];
  endproperty
  a_evt_latch: assert property (p_evt_latch) else $error("event not latched");

  property p_evt_hold;
    @(posedge pclk) disable iff (!presetn)
    (evt_q[0][`P5_CUR_BIT] && !rd_take && !cmd_wr)
      |=> evt_q[0][`P5_CUR_BIT];
  endproperty
  a_evt_hold: assert property (p_evt_hold) else $error("event lost");

  property p_rd_clear;
    @(posedge pclk) disable iff (!presetn)
    (rd_take && paddr == `OFS_EVT && prev_q[0] == cond_now[0])
      |=> evt_q[0] == '0;
  endproperty
  a_rd_clear: assert property (p_rd_clear) else $error("read did not clear");

  property p_over_bit;
    @(posedge pclk) disable iff (!presetn)
    (p5_current > limit_q) |=> cond_now[0][`P5_CUR_BIT];
  endproperty
  a_over_bit: assert property (p_over_bit) else $error("p5 bit missing");

  property p_cls_retrigger;
    @(posedge pclk) disable iff (!presetn)
    (cls && cond_now[0][`P5_CUR_BIT]) ##1 cond_now[0][`P5_CUR_BIT]
      |=> evt_q[0][`P5_CUR_BIT];
  endproperty
  a_cls_retrigger: assert property (p_cls_retrigger) else $error("no retrigger");

  property p_unused_zero;
    @(posedge pclk) disable iff (!presetn)
    ((evt_q[1] | cond_now[1]) & ~USED[`GRP_W +: `GRP_W]) == '0;
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused bit set");

  property p_preset;
    @(posedge pclk) disable iff (!presetn)
    preset |=> (en_q[0] == `EN_PRESET) && (en_q[NG-1] == `EN_PRESET);
  endproperty
  a_preset: assert property (p_preset) else $error("preset left mask");

  property p_summary;
    @(posedge pclk) disable iff (!presetn)
    (en_q[2] == '0) |-> !sum_evt[2] && !sum_cond[2];
  endproperty
  a_summary: assert property (p_summary) else $error("masked summary set");

  property p_alarm_off;
    @(posedge pclk) disable iff (!presetn)
    (!cur_over)[*2] |=> !alarm_flash;
  endproperty
  a_alarm_off: assert property (p_alarm_off) else $error("alarm stuck");

  property p_cond_noside;
    @(posedge pclk) disable iff (!presetn)
    (op.rd && op.addr[3:0] == `OFS_COND && !cmd_wr) |=> $stable(en_q[0]);
  endproperty
  a_cond_noside: assert property (p_cond_noside) else $error("cond read side");
endmodule // status_bank
`default_nettype wire

// File: verification/apb_host.sv
/*
  host side model: an apb master that software uses to reach the bank.
  assumes a single rising-edge pclk shared with the bank.
*/
`timescale 1ns/1ps
`default_nettype none
// ====================================================================
// apb master
module apb_host (
  input  wire logic        pclk,    // bus clock
  output logic             psel,    // select
  output logic             penable, // access phase
  output logic             pwrite,  // direction
  output logic [7:0]       paddr,   // byte address
  output logic [31:0]      pwdata,  // write data
  input  wire logic [31:0] prdata,  // read data
  input  wire logic        pready,  // slave ready
  input  wire logic        pslverr  // slave error
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // request held until pready is seen high; the bench timeout ends a hang
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule // apb_host
`default_nettype wire

// File: verification/test_status_event_condition_enable.sv
/*
  self-checking bench of the status bank: apb accesses with expected values.
  assumes apb_host.sv and the rtl files are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "status_params.svh"
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin \
  n_mismatch++; $display("[FAIL] t=%0t got %h exp %h", $time, got, exp); \
  end end
module test_status_event_condition_enable;
  import status_pkg::*;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic        alarm_flash;
  logic [95:0] cond;
  logic [15:0] p5;
  logic [31:0] q;
  logic        e;
  int          n_mismatch;
  int          n_checks;
  int          cyc;
  int          hi;
  int          lo;
  apb_host host (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  // short blink period keeps the flashing visible in a few cycles
  status_bank #(.BLINK_CYCLES(4)) dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .monitor_cond(cond), .p5_current(p5), .irq(irq),
    .alarm_flash(alarm_flash));
  // ==================================================================
  // tasks
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, q, e);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    host.xfer(1'b0, a, 32'h0, q, e);
    `CHK(q, exp)
  endtask
  // condition path is two sync edges plus the event edge
  task automatic grp(input int g, input logic [15:0] v);
    @(posedge pclk);
    cond[16*g +: 16] <= v;
    repeat (5) @(posedge pclk);
  endtask
  task automatic blink(input int n);
    hi = 0;
    lo = 0;
    repeat (n) begin
      @(posedge pclk);
      if (alarm_flash === 1'b1) hi++;
      else if (alarm_flash === 1'b0) lo++;
    end
  endtask
  // ==================================================================
  // clock, reset, timeout
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      end_sim();
    end
  end
  // ==================================================================
  // scenarios
  initial begin
    presetn = 1'b0;
    cond = 96'h0;
    p5 = 16'h0000;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(8'h10, 32'h0);
    rd_chk(`OFS_P5_LIMIT, 32'h0000ffff);
    grp(1, 16'h1081);
    rd_chk(8'h14, 32'h81);
    rd_chk(8'h14, 32'h81);
    rd_chk(8'h10, 32'h81);
    rd_chk(8'h10, 32'h0);
    wr(8'h18, 32'h2);
    rd_chk(`OFS_QUES_COND, 32'h0);
    wr(8'h18, 32'h80);
    rd_chk(`OFS_QUES_COND, 32'h2);
    rd_chk(8'h14, 32'h81);
    wr(8'h18, 32'h2);
    grp(1, 16'h0083);
    grp(1, 16'h0081);
    rd_chk(`OFS_QUES_EVT, 32'h2);
    rd_chk(8'h10, 32'h2);
    `CHK(irq, 1'b0)
    rd_chk(`OFS_IRQ_STS, 32'h2);
    wr(`OFS_IRQ_EN, 32'h2);
    repeat (2) @(posedge pclk);
    `CHK(irq, 1'b1)
    wr(`OFS_IRQ_CLR, 32'h2);
    repeat (2) @(posedge pclk);
    `CHK(irq, 1'b0)
    wr(`OFS_CMD, 32'h2);
    rd_chk(8'h18, 32'h0);
    grp(2, 16'h0001);
    // drop the cause first: a lasting one would re-set after the command
    grp(2, 16'h0000);
    wr(`OFS_CMD, 32'h4);
    rd_chk(8'h20, 32'h0);
    @(posedge pclk);
    p5 <= 16'h0064;
    wr(`OFS_P5_LIMIT, 32'h32);
    repeat (5) @(posedge pclk);
    rd_chk(8'h04, 32'h4);
    rd_chk(8'h00, 32'h4);
    blink(20);
    `CHK(hi > 0 && lo > 0, 1'b1)
    rd_chk(8'h00, 32'h0);
    wr(`OFS_CMD, 32'h1);
    repeat (3) @(posedge pclk);
    rd_chk(8'h00, 32'h4);
    wr(`OFS_CMD, 32'h1);
    wr(`OFS_P5_LIMIT, 32'hffff);
    repeat (5) @(posedge pclk);
    rd_chk(8'h00, 32'h4);
    rd_chk(8'h04, 32'h0);
    blink(12);
    `CHK(lo, 12)
    host.xfer(1'b0, 8'h7c, 32'h0, q, e);
    `CHK(e, 1'b1)
    `CHK(q, 32'h0)
    end_sim();
  end
endmodule // test_status_event_condition_enable
`default_nettype wire
